// ===== jdp_pkg.sv
// package: shared constants and types for the jtag debug port link
package jdp_pkg;

    // ------------------------------------------------------------
    // tap controller states, standard boundary-scan encoding
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_EX2_DR = 4'h0,
        TAP_EX1_DR = 4'h1,
        TAP_SH_DR  = 4'h2,
        TAP_PS_DR  = 4'h3,
        TAP_SEL_IR = 4'h4,
        TAP_UP_DR  = 4'h5,
        TAP_CAP_DR = 4'h6,
        TAP_SEL_DR = 4'h7,
        TAP_EX2_IR = 4'h8,
        TAP_EX1_IR = 4'h9,
        TAP_SH_IR  = 4'hA,
        TAP_PS_IR  = 4'hB,
        TAP_RTI    = 4'hC,
        TAP_UP_IR  = 4'hD,
        TAP_CAP_IR = 4'hE,
        TAP_TLR    = 4'hF
    } jdp_tap_t;

    // ------------------------------------------------------------
    // instruction and data registers
    // ------------------------------------------------------------
    localparam int unsigned JDP_IR_W = 4;
    localparam logic [3:0] JDP_IR_CAPTURE = 4'h1;
    localparam logic [3:0] JDP_INS_IDCODE = 4'h2;
    localparam logic [3:0] JDP_INS_STATUS = 4'h7;
    localparam logic [3:0] JDP_INS_BYPASS = 4'hF;
    localparam int unsigned JDP_DR_W = 32;
    localparam int unsigned JDP_STAT_W = 8;
    localparam int unsigned JDP_STAT_ACTIVE_BIT = 0;
    localparam int unsigned JDP_STAT_EXIT_BIT = 1;
    // arbitrary identification value; bit 0 kept at one as boundary-scan expects
    localparam logic [31:0] JDP_IDCODE_DEFAULT = 32'h0ABC_D001;

    // ------------------------------------------------------------
    // host timing
    // ------------------------------------------------------------
    localparam int unsigned JDP_CLK_NS = 50;
    localparam int unsigned JDP_TCK_HALF_NS = 200;
    localparam int unsigned JDP_TCK_HALF_CYC = (JDP_TCK_HALF_NS + JDP_CLK_NS - 1) / JDP_CLK_NS;
    localparam logic [2:0] JDP_PH_RISE = 3'(JDP_TCK_HALF_CYC);
    localparam logic [2:0] JDP_PH_LAST = 3'(2 * JDP_TCK_HALF_CYC - 1);
    localparam int unsigned JDP_DE_PULL_NS = 1000;
    localparam int unsigned JDP_DE_PULL_CYC = (JDP_DE_PULL_NS + JDP_CLK_NS - 1) / JDP_CLK_NS;
    localparam logic [4:0] JDP_DE_PULL_CNT = 5'(JDP_DE_PULL_CYC);

    // ------------------------------------------------------------
    // host scan sequencing
    // ------------------------------------------------------------
    localparam int unsigned JDP_LEN_W = 6;
    localparam logic [5:0] JDP_RST_ONES = 6'h05;
    localparam logic [5:0] JDP_HEAD_IR_LAST = 6'h03;
    localparam logic [5:0] JDP_HEAD_DR_LAST = 6'h02;
    localparam logic [5:0] JDP_HEAD_IR_ONES = 6'h02;
    localparam logic [5:0] JDP_HEAD_DR_ONES = 6'h01;
    localparam logic [5:0] JDP_TAIL_LAST = 6'h01;
    localparam logic [5:0] JDP_LEN_MAX = 6'h20;

    typedef enum logic [2:0] {
        HS_RST   = 3'h0,
        HS_IDLE  = 3'h1,
        HS_HEAD  = 3'h2,
        HS_SHIFT = 3'h3,
        HS_TAIL  = 3'h4,
        HS_DONE  = 3'h5
    } jdp_host_t;

endpackage : jdp_pkg

// ===== jdp_link_if.sv
// interface: jtag and debug event pins between debugger and device
`timescale 1ns/1ns
interface jdp_link_if;
    logic tck_drv;
    logic tck_oe;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic dev_tdo;
    logic dev_tdo_oe;
    logic tdo;
    logic dev_de_oe;
    logic host_de_oe;
    logic debug_event_n;

    // pull-down on the test clock: undriven means low, no edges
    assign tck = tck_oe & tck_drv;
    // released data output reads high at the debugger
    assign tdo = dev_tdo_oe ? dev_tdo : 1'b1;
    // open drain with weak pull-up
    assign debug_event_n = ~(dev_de_oe | host_de_oe);

    modport dev (
        input tck,
        input tms,
        input tdi,
        input trst_n,
        input debug_event_n,
        output dev_tdo,
        output dev_tdo_oe,
        output dev_de_oe
    );

    modport host (
        output tck_drv,
        output tck_oe,
        output tms,
        output tdi,
        output trst_n,
        output host_de_oe,
        input tdo,
        input debug_event_n
    );
endinterface : jdp_link_if

// ===== jdp_device.sv
// device end: tap controller, scan registers and debug event handshake
`timescale 1ns/1ns
module jdp_device
    import jdp_pkg::*;
#(
    parameter logic [31:0] P_IDCODE = JDP_IDCODE_DEFAULT
)(
    jdp_link_if.dev link,
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_debug_exit,
    output logic o_debug_mode,
    output logic o_debug_enter
);

    // ------------------------------------------------------------
    // tap state machine, test clock domain
    // ------------------------------------------------------------
    jdp_tap_t tap_q;
    jdp_tap_t tap_d;
    logic [JDP_IR_W-1:0] ir_q;
    logic [JDP_IR_W-1:0] ir_d;
    logic [JDP_IR_W-1:0] irsh_q;
    logic [JDP_IR_W-1:0] irsh_d;
    logic [JDP_DR_W-1:0] dr_q;
    logic [JDP_DR_W-1:0] dr_d;
    logic exit_tgl_q;
    logic exit_tgl_d;
    logic act_s1_q;
    logic act_s2_q;
    logic act_s3_q;
    logic act_q;
    logic act_d;
    logic dbg_q;

    always_comb
    begin
        tap_d = tap_q;
        case (tap_q)
            TAP_TLR:    tap_d = link.tms ? TAP_TLR : TAP_RTI;
            TAP_RTI:    tap_d = link.tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_d = link.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_d = link.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_d = link.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_d = link.tms ? TAP_UP_DR : TAP_PS_DR;
            TAP_PS_DR:  tap_d = link.tms ? TAP_EX2_DR : TAP_PS_DR;
            TAP_EX2_DR: tap_d = link.tms ? TAP_UP_DR : TAP_SH_DR;
            TAP_UP_DR:  tap_d = link.tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_d = link.tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_d = link.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_d = link.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_d = link.tms ? TAP_UP_IR : TAP_PS_IR;
            TAP_PS_IR:  tap_d = link.tms ? TAP_EX2_IR : TAP_PS_IR;
            TAP_EX2_IR: tap_d = link.tms ? TAP_UP_IR : TAP_SH_IR;
            TAP_UP_IR:  tap_d = link.tms ? TAP_SEL_DR : TAP_RTI;
            default:    tap_d = TAP_TLR;
        endcase
    end

    // ------------------------------------------------------------
    // instruction and data scan paths
    // ------------------------------------------------------------
    always_comb
    begin
        ir_d = ir_q;
        irsh_d = irsh_q;
        dr_d = dr_q;
        exit_tgl_d = exit_tgl_q;
        act_d = (act_s2_q == act_s3_q) ? act_s3_q : act_q;
        case (tap_q)
            TAP_TLR:
            begin
                ir_d = JDP_INS_IDCODE;
            end
            TAP_CAP_IR:
            begin
                irsh_d = JDP_IR_CAPTURE;
            end
            TAP_SH_IR:
            begin
                irsh_d = {link.tdi, irsh_q[JDP_IR_W-1:1]};
            end
            TAP_UP_IR:
            begin
                ir_d = irsh_q;
            end
            TAP_CAP_DR:
            begin
                case (ir_q)
                    JDP_INS_IDCODE: dr_d = P_IDCODE;
                    JDP_INS_STATUS:
                    begin
                        dr_d = '0;
                        dr_d[JDP_STAT_ACTIVE_BIT] = act_q;
                    end
                    default: dr_d = '0;
                endcase
            end
            TAP_SH_DR:
            begin
                // unknown codes behave as the one-bit bypass path
                case (ir_q)
                    JDP_INS_IDCODE: dr_d = {link.tdi, dr_q[JDP_DR_W-1:1]};
                    JDP_INS_STATUS: dr_d[JDP_STAT_W-1:0] = {link.tdi, dr_q[JDP_STAT_W-1:1]};
                    default: dr_d[0] = link.tdi;
                endcase
            end
            TAP_UP_DR:
            begin
                if ((ir_q == JDP_INS_STATUS) && dr_q[JDP_STAT_EXIT_BIT])
                begin
                    exit_tgl_d = ~exit_tgl_q;
                end
            end
            default:
            begin
                ir_d = ir_q;
            end
        endcase
    end

    // test clock is gated by the debugger, so nothing here may wait on a free-running edge
    always_ff @(posedge link.tck or negedge link.trst_n)
    begin
        if (!link.trst_n)
        begin
            tap_q <= TAP_TLR;
            ir_q <= JDP_INS_IDCODE;
            irsh_q <= JDP_IR_CAPTURE;
            dr_q <= '0;
            exit_tgl_q <= 1'b0;
            act_s1_q <= 1'b0;
            act_s2_q <= 1'b0;
            act_s3_q <= 1'b0;
            act_q <= 1'b0;
        end
        else
        begin
            tap_q <= tap_d;
            ir_q <= ir_d;
            irsh_q <= irsh_d;
            dr_q <= dr_d;
            exit_tgl_q <= exit_tgl_d;
            act_s1_q <= dbg_q;
            act_s2_q <= act_s1_q;
            act_s3_q <= act_s2_q;
            act_q <= act_d;
        end
    end

    // ------------------------------------------------------------
    // data output, falling test clock
    // ------------------------------------------------------------
    logic tdo_q;
    logic tdo_d;
    logic tdo_oe_q;
    logic tdo_oe_d;

    always_comb
    begin
        tdo_d = tdo_q;
        tdo_oe_d = 1'b0;
        case (tap_q)
            TAP_SH_IR:
            begin
                tdo_d = irsh_q[0];
                tdo_oe_d = 1'b1;
            end
            TAP_SH_DR:
            begin
                tdo_d = dr_q[0];
                tdo_oe_d = 1'b1;
            end
            default:
            begin
                tdo_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(negedge link.tck or negedge link.trst_n)
    begin
        if (!link.trst_n)
        begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign link.dev_tdo = tdo_q;
    assign link.dev_tdo_oe = tdo_oe_q;

    // ------------------------------------------------------------
    // debug event handshake, system clock domain
    // ------------------------------------------------------------
    logic de_s1_q;
    logic de_s2_q;
    logic de_s3_q;
    logic de_f_q;
    logic de_f_d;
    logic de_prev_q;
    logic dbg_d;
    logic enter_q;
    logic enter_d;
    logic xt_s1_q;
    logic xt_s2_q;
    logic xt_s3_q;
    logic xt_f_q;
    logic xt_f_d;
    logic xt_seen_q;
    logic exit_evt;

    always_comb
    begin
        de_f_d = (de_s2_q == de_s3_q) ? de_s3_q : de_f_q;
        xt_f_d = (xt_s2_q == xt_s3_q) ? xt_s3_q : xt_f_q;
        exit_evt = xt_f_q != xt_seen_q;
        // edge, not level: our own acknowledge holds the line low
        enter_d = !dbg_q && de_prev_q && !de_f_q;
        dbg_d = dbg_q;
        if (enter_d)
        begin
            dbg_d = 1'b1;
        end
        else if (i_debug_exit || exit_evt)
        begin
            dbg_d = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            de_s1_q <= 1'b1;
            de_s2_q <= 1'b1;
            de_s3_q <= 1'b1;
            de_f_q <= 1'b1;
            de_prev_q <= 1'b1;
            dbg_q <= 1'b0;
            enter_q <= 1'b0;
            xt_s1_q <= 1'b0;
            xt_s2_q <= 1'b0;
            xt_s3_q <= 1'b0;
            xt_f_q <= 1'b0;
            xt_seen_q <= 1'b0;
        end
        else
        begin
            de_s1_q <= link.debug_event_n;
            de_s2_q <= de_s1_q;
            de_s3_q <= de_s2_q;
            de_f_q <= de_f_d;
            de_prev_q <= de_f_q;
            dbg_q <= dbg_d;
            enter_q <= enter_d;
            xt_s1_q <= exit_tgl_q;
            xt_s2_q <= xt_s1_q;
            xt_s3_q <= xt_s2_q;
            xt_f_q <= xt_f_d;
            xt_seen_q <= xt_f_q;
        end
    end

    // only ever pulls low; release leaves the line to the pull-up
    assign link.dev_de_oe = dbg_q;
    assign o_debug_mode = dbg_q;
    assign o_debug_enter = enter_q;

endmodule : jdp_device

// ===== jdp_host.sv
// host end: debugger that sequences scans and requests debug mode
`timescale 1ns/1ns
module jdp_host
    import jdp_pkg::*;
(
    jdp_link_if.host link,
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic i_cmd_ir,
    input wire logic [JDP_LEN_W-1:0] i_cmd_len,
    input wire logic [JDP_DR_W-1:0] i_cmd_data,
    output logic o_rsp_valid,
    output logic [JDP_DR_W-1:0] o_rsp_data,
    input wire logic i_tap_reset,
    input wire logic i_debug_req,
    output logic o_debug_ack
);

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------
    jdp_host_t st_q;
    jdp_host_t st_d;
    logic [JDP_LEN_W-1:0] cnt_q;
    logic [JDP_LEN_W-1:0] cnt_d;
    logic [JDP_LEN_W-1:0] len_q;
    logic [JDP_LEN_W-1:0] len_d;
    logic [2:0] ph_q;
    logic [2:0] ph_d;
    logic ir_q;
    logic ir_d;
    logic [JDP_DR_W-1:0] sh_q;
    logic [JDP_DR_W-1:0] sh_d;
    logic [JDP_DR_W-1:0] cap_q;
    logic [JDP_DR_W-1:0] cap_d;
    logic [JDP_DR_W-1:0] rsp_q;
    logic [JDP_DR_W-1:0] rsp_d;
    logic rsp_v_q;
    logic rsp_v_d;
    logic tck_q;
    logic tck_d;
    logic tck_oe_q;
    logic tms_q;
    logic tms_d;
    logic tdi_q;
    logic tdi_d;
    logic trst_q;
    logic tdo_s1_q;
    logic tdo_s2_q;
    logic tdo_s3_q;
    logic tdo_f_q;
    logic tdo_f_d;
    logic busy;
    logic cur_tms;
    logic cur_tdi;
    logic [JDP_LEN_W-1:0] len_last;

    always_comb
    begin
        busy = (st_q == HS_RST) || (st_q == HS_HEAD) || (st_q == HS_SHIFT) || (st_q == HS_TAIL);
        len_last = len_q - 6'h01;
        cur_tms = 1'b0;
        cur_tdi = 1'b0;
        case (st_q)
            HS_RST: cur_tms = cnt_q < JDP_RST_ONES;
            HS_HEAD: cur_tms = cnt_q < (ir_q ? JDP_HEAD_IR_ONES : JDP_HEAD_DR_ONES);
            HS_SHIFT:
            begin
                cur_tms = cnt_q == len_last;
                cur_tdi = sh_q[cnt_q[4:0]];
            end
            HS_TAIL: cur_tms = cnt_q == 6'h00;
            default: cur_tms = 1'b0;
        endcase
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        len_d = len_q;
        ir_d = ir_q;
        sh_d = sh_q;
        cap_d = cap_q;
        rsp_d = rsp_q;
        rsp_v_d = 1'b0;
        ph_d = 3'h0;
        tms_d = tms_q;
        tdi_d = tdi_q;
        tdo_f_d = (tdo_s2_q == tdo_s3_q) ? tdo_s3_q : tdo_f_q;
        if (busy)
        begin
            ph_d = (ph_q == JDP_PH_LAST) ? 3'h0 : ph_q + 3'h1;
            if (ph_q == 3'h0)
            begin
                tms_d = cur_tms;
                tdi_d = cur_tdi;
            end
        end
        tck_d = busy && (ph_d >= JDP_PH_RISE);
        case (st_q)
            HS_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    st_d = HS_HEAD;
                    cnt_d = 6'h00;
                    ir_d = i_cmd_ir;
                    sh_d = i_cmd_data;
                    cap_d = '0;
                    // zero means one bit, anything longer is cut to a word
                    len_d = (i_cmd_len == 6'h00) ? 6'h01 :
                            (i_cmd_len > JDP_LEN_MAX) ? JDP_LEN_MAX : i_cmd_len;
                end
            end
            HS_DONE:
            begin
                rsp_v_d = 1'b1;
                rsp_d = cap_q;
                st_d = HS_IDLE;
            end
            default:
            begin
                if (ph_q == JDP_PH_LAST)
                begin
                    cnt_d = cnt_q + 6'h01;
                    case (st_q)
                        HS_RST: if (cnt_q == JDP_RST_ONES) st_d = HS_IDLE;
                        HS_HEAD:
                        begin
                            if (cnt_q == (ir_q ? JDP_HEAD_IR_LAST : JDP_HEAD_DR_LAST))
                            begin
                                st_d = HS_SHIFT;
                                cnt_d = 6'h00;
                            end
                        end
                        HS_SHIFT:
                        begin
                            // bit was put out on the falling edge opening this step
                            cap_d[cnt_q[4:0]] = tdo_f_q;
                            if (cnt_q == len_last)
                            begin
                                st_d = HS_TAIL;
                                cnt_d = 6'h00;
                            end
                        end
                        HS_TAIL: if (cnt_q == JDP_TAIL_LAST) st_d = HS_DONE;
                        default: st_d = HS_IDLE;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_q <= HS_RST;
            cnt_q <= 6'h00;
            len_q <= 6'h01;
            ph_q <= 3'h0;
            ir_q <= 1'b0;
            sh_q <= '0;
            cap_q <= '0;
            rsp_q <= '0;
            rsp_v_q <= 1'b0;
            tck_q <= 1'b0;
            tck_oe_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b1;
            trst_q <= 1'b0;
            tdo_s1_q <= 1'b1;
            tdo_s2_q <= 1'b1;
            tdo_s3_q <= 1'b1;
            tdo_f_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            ph_q <= ph_d;
            ir_q <= ir_d;
            sh_q <= sh_d;
            cap_q <= cap_d;
            rsp_q <= rsp_d;
            rsp_v_q <= rsp_v_d;
            tck_q <= tck_d;
            tck_oe_q <= 1'b1;
            tms_q <= tms_d;
            tdi_q <= tdi_d;
            trst_q <= ~i_tap_reset;
            tdo_s1_q <= link.tdo;
            tdo_s2_q <= tdo_s1_q;
            tdo_s3_q <= tdo_s2_q;
            tdo_f_q <= tdo_f_d;
        end
    end

    // ------------------------------------------------------------
    // debug event request
    // ------------------------------------------------------------
    logic [4:0] pull_q;
    logic [4:0] pull_d;
    logic de_s1_q;
    logic de_s2_q;
    logic de_s3_q;
    logic de_f_q;
    logic de_f_d;
    logic ack_q;
    logic ack_d;

    always_comb
    begin
        de_f_d = (de_s2_q == de_s3_q) ? de_s3_q : de_f_q;
        pull_d = pull_q;
        if (i_debug_req)
        begin
            pull_d = JDP_DE_PULL_CNT;
        end
        else if (pull_q != 5'h00)
        begin
            pull_d = pull_q - 5'h01;
        end
        // low once our own pull is gone counts as the device, though the filtered line shows our pull for four cycles more
        ack_d = !de_f_q && (pull_q == 5'h00);
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pull_q <= 5'h00;
            de_s1_q <= 1'b1;
            de_s2_q <= 1'b1;
            de_s3_q <= 1'b1;
            de_f_q <= 1'b1;
            ack_q <= 1'b0;
        end
        else
        begin
            pull_q <= pull_d;
            de_s1_q <= link.debug_event_n;
            de_s2_q <= de_s1_q;
            de_s3_q <= de_s2_q;
            de_f_q <= de_f_d;
            ack_q <= ack_d;
        end
    end

    assign link.tck_drv = tck_q;
    assign link.tck_oe = tck_oe_q;
    assign link.tms = tms_q;
    assign link.tdi = tdi_q;
    assign link.trst_n = trst_q;
    assign link.host_de_oe = pull_q != 5'h00;
    assign o_cmd_ready = st_q == HS_IDLE;
    assign o_rsp_valid = rsp_v_q;
    assign o_rsp_data = rsp_q;
    assign o_debug_ack = ack_q;

endmodule : jdp_host

// ===== jdp_link_properties.sv
// checker: concurrent properties on the jtag debug port link
`timescale 1ns/1ns
module jdp_link_properties (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic dev_tdo,
    input wire logic dev_tdo_oe,
    input wire logic dev_de_oe,
    input wire logic host_de_oe
);
    // ------------------------------------------------------------
    // test clock domain: shift window follows mode select
    // ------------------------------------------------------------
    sequence five_ones_s;
        tms [*5];
    endsequence
    shift_hold_a:
        assert property (@(posedge tck) disable iff (!trst_n) dev_tdo_oe && !tms |=> dev_tdo_oe)
        else $error("data output released inside shift");
    shift_exit_a:
        assert property (@(posedge tck) disable iff (!trst_n) dev_tdo_oe && tms |=> !dev_tdo_oe)
        else $error("data output still driven after shift exit");
    reset_idle_a:
        assert property (@(posedge tck) disable iff (!trst_n) five_ones_s |=> !dev_tdo_oe)
        else $error("data output driven after five ones on mode select");
    // ------------------------------------------------------------
    // system clock domain: edges, resets and debug handshake
    // ------------------------------------------------------------
    // a change seen while the test clock is high would mean a rising-edge update
    tdo_fall_a:
        assert property (@(posedge i_clock) disable iff (!i_rst_b || !trst_n)
            $changed(dev_tdo) |-> !tck)
        else $error("data output changed outside a falling test clock");
    oe_fall_a:
        assert property (@(posedge i_clock) disable iff (!i_rst_b || !trst_n)
            $changed(dev_tdo_oe) |-> !tck)
        else $error("output enable changed outside a falling test clock");
    trst_clear_a:
        assert property (@(posedge i_clock) disable iff (!i_rst_b) !trst_n |-> !dev_tdo_oe)
        else $error("data output driven during test reset");
    de_ack_a:
        assert property (@(posedge i_clock) disable iff (!i_rst_b)
            $rose(host_de_oe) && !dev_de_oe |-> ##[2:8] dev_de_oe)
        else $error("debug entry not acknowledged in time");
    de_cause_a:
        assert property (@(posedge i_clock) disable iff (!i_rst_b)
            $rose(dev_de_oe) |-> $past(host_de_oe, 2))
        else $error("debug acknowledge without a request");
    tms_stable_a:
        assert property (@(posedge i_clock) disable iff (!i_rst_b)
            tck |-> $stable(tms) && $stable(tdi))
        else $error("mode select or data input moved while test clock high");
endmodule : jdp_link_properties

// ===== jtag_debug_port_tb.sv
// testbench: host and device ends joined across the jtag debug link
`timescale 1ns/1ns
module jtag_debug_port_tb;
    import jdp_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h1357_9BDF; // arbitrary value, bit 0 set
    typedef struct packed {logic ir; logic [5:0] len; logic [31:0] data; logic [31:0] want;} jdp_row_t;
    // bypass delays by one bit and captures zero; oversized length clips to 32
    jdp_row_t rows [7] = '{'{1'b1, 6'h04, 32'h2, 32'h1}, '{1'b0, 6'h28, 32'h0, ID_VAL},
        '{1'b1, 6'h04, 32'hF, 32'h1}, '{1'b0, 6'h08, 32'hA5, 32'h4A},
        '{1'b1, 6'h04, 32'h3, 32'h1}, '{1'b0, 6'h04, 32'hF, 32'hE}, '{1'b0, 6'h00, 32'h1, 32'h0}};
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic cmd_valid = 1'b0, cmd_ir = 1'b0, tap_reset = 1'b0, debug_req = 1'b0, debug_exit = 1'b0;
    logic [5:0] cmd_len = 6'h00;
    logic [31:0] cmd_data = 32'h0, rsp, rsp_data;
    logic cmd_ready, rsp_valid, debug_ack, debug_mode, debug_enter;
    int bad_count = 0, tests_run = 0, n, hits;

    jdp_link_if link_bus();
    jdp_device #(.P_IDCODE(ID_VAL)) u_jdp_device (.link(link_bus), .i_clock(i_clock),
        .i_rst_b(i_rst_b), .i_debug_exit(debug_exit), .o_debug_mode(debug_mode),
        .o_debug_enter(debug_enter));
    jdp_host u_jdp_host (.link(link_bus), .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_ir(cmd_ir), .i_cmd_len(cmd_len),
        .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .i_tap_reset(tap_reset), .i_debug_req(debug_req), .o_debug_ack(debug_ack));
    jdp_link_properties u_props (.i_clock(i_clock), .i_rst_b(i_rst_b), .tck(link_bus.tck),
        .tms(link_bus.tms), .tdi(link_bus.tdi), .trst_n(link_bus.trst_n),
        .dev_tdo(link_bus.dev_tdo), .dev_tdo_oe(link_bus.dev_tdo_oe),
        .dev_de_oe(link_bus.dev_de_oe), .host_de_oe(link_bus.host_de_oe));

    always #25 i_clock = ~i_clock;

    // ------------------------------------------------------------
    // helpers: scan and raise_req drive at the falling clock edge
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic scan(input logic ir, input logic [5:0] len, input logic [31:0] data);
        for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
            @(negedge i_clock);
        cmd_ir = ir;
        cmd_len = len;
        cmd_data = data;
        cmd_valid = 1'b1;
        @(negedge i_clock);
        cmd_valid = 1'b0;
        for (n = 0; n < 500 && rsp_valid !== 1'b1; n++)
            @(negedge i_clock);
        chk({31'h0, rsp_valid}, 32'h1);
        rsp = rsp_data;
    endtask : scan

    task automatic raise_req;
        debug_req = 1'b1;
        @(negedge i_clock);
        debug_req = 1'b0;
    endtask : raise_req

    task automatic wait_mode(input logic want);
        for (n = 0; n < 60 && debug_mode !== want; n++)
            @(negedge i_clock);
        chk({31'h0, debug_mode}, {31'h0, want});
    endtask : wait_mode

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (8) @(negedge i_clock);
        i_rst_b = 1'b1;
        foreach (rows[i])
        begin
            scan(rows[i].ir, rows[i].len, rows[i].data);
            chk(rsp, rows[i].want);
        end
        chk({31'h0, link_bus.tdo}, 32'h1);
        $display("scan table done");
        raise_req();
        wait_mode(1'b1);
        for (n = 0; n < 60 && debug_ack !== 1'b1; n++)
            @(negedge i_clock);
        chk({31'h0, debug_ack}, 32'h1);
        // a second request while active must not re-enter
        hits = 0;
        raise_req();
        repeat (40)
        begin
            @(negedge i_clock);
            if (debug_enter === 1'b1)
                hits++;
        end
        chk(32'(hits), 32'h0);
        scan(1'b1, 6'h04, 32'h7);
        scan(1'b0, 6'h08, 32'h0);
        chk(rsp, 32'h1);
        scan(1'b0, 6'h08, 32'h2);
        wait_mode(1'b0);
        repeat (2) @(negedge i_clock);
        chk({31'h0, link_bus.debug_event_n}, 32'h1);
        raise_req();
        wait_mode(1'b1);
        chk({30'h0, debug_mode, debug_enter}, 32'h3);
        debug_exit = 1'b1;
        @(negedge i_clock);
        debug_exit = 1'b0;
        wait_mode(1'b0);
        chk({31'h0, debug_mode}, 32'h0);
        $display("debug event tests done");
        // mid-run reset with test reset held past it; bypass must give way to identity
        scan(1'b1, 6'h04, 32'hF);
        tap_reset = 1'b1;
        i_rst_b = 1'b0;
        repeat (3) @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (3) @(negedge i_clock);
        chk({30'h0, link_bus.trst_n, link_bus.dev_tdo_oe}, 32'h0);
        tap_reset = 1'b0;
        scan(1'b0, 6'h20, 32'h0);
        chk(rsp, ID_VAL);
        $display("reset tests done");
        complete_run();
    end

    initial
    begin
        #2000000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : jtag_debug_port_tb
